// ==== rtl/ntt_defines.svh ====
`ifndef NTT_DEFINES_SVH
`define NTT_DEFINES_SVH
// =====================================================
// mode codes on request pins, active-low as seen at pins
`define NTT_CODE_NAND 4'h2
`define NTT_CODE_ID 4'he
`define NTT_CODE_OFF 4'hf
// =====================================================
// chain lengths
`define NTT_CH0_LEN 72
`define NTT_CH1_LEN 72
`define NTT_CH2_LEN 70
`define NTT_CH3_LEN 68
`define NTT_CH_MAX 72
// =====================================================
// identity values, arbitrary neutral defaults
`define NTT_DEV_ID 16'h1234
`define NTT_REV_ID 8'h01
`define NTT_MFG_ID 32'h00a5_5a00
`define NTT_RESET_MODE 2'h0
`endif

// ==== rtl/ntt_pkg.sv ====
package ntt_pkg;
  typedef enum logic [1:0] {NTT_NORMAL, NTT_NAND, NTT_ID} ntt_mode_t;
  typedef logic [71:0] ntt_chain_t;
endpackage

// ==== rtl/ntt_chain_if.sv ====
`timescale 1ns/10ps
interface ntt_chain_if;
  logic [71:0] members;
  logic [6:0] len;
  logic out;
  modport src (output members, output len, input out);
  modport nand_side (input members, input len, output out);
endinterface

// ==== rtl/ntt_nand_chain.sv ====
`timescale 1ns/10ps
module ntt_nand_chain (
  // chain members and result
  ntt_chain_if.nand_side ch
);
  logic [72:0] stage;
  assign stage[0] = 1'b1;
  // =====================================================
  // cascaded nand, unused tail passes through
  genvar i;
  generate
    for (i = 0; i < 72; i++) begin : g_stage
      assign stage[i+1] = (7'(i) < ch.len) ?
        ((i == 0) ? ~ch.members[0] : ~(stage[i] & ch.members[i])) : stage[i];
    end
  endgenerate
  assign ch.out = stage[72];
endmodule // ntt_nand_chain

// ==== rtl/ntt_test_ctrl.sv ====
`timescale 1ns/10ps
`include "ntt_defines.svh"
module ntt_test_ctrl (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // strap pins
  input wire logic test_strobe_n,
  input wire logic [3:0] pci_req_n,
  input wire logic pci_hold_request_n,
  // chain members, index 0 is first element
  input wire ntt_pkg::ntt_chain_t chain0_pins,
  input wire ntt_pkg::ntt_chain_t chain1_pins,
  input wire ntt_pkg::ntt_chain_t chain2_pins,
  input wire ntt_pkg::ntt_chain_t chain3_pins,
  // normal-mode grants and address/data
  input wire logic [3:0] func_gnt_n,
  input wire logic [31:0] func_ad_o,
  input wire logic func_ad_oe,
  // pins
  output logic [3:0] pci_gnt_n,
  output logic [31:0] ad_o,
  output logic ad_oe,
  output logic outputs_float,
  output logic pulls_enable,
  output ntt_pkg::ntt_mode_t mode
);
  import ntt_pkg::*;
  // =====================================================
  // three-stage pin synchronisers
  logic [2:0] strobe_sync_reg, strobe_sync_next;
  logic [2:0] hold_sync_reg, hold_sync_next;
  logic [3:0] req_s1_reg, req_s2_reg, req_s3_reg;
  logic [3:0] req_s1_next, req_s2_next, req_s3_next;
  logic strobe_reg, strobe_next;
  logic hold_reg, hold_next;
  logic [3:0] req_reg, req_next;
  always_comb begin
    strobe_sync_next = {strobe_sync_reg[1:0], test_strobe_n};
    hold_sync_next = {hold_sync_reg[1:0], pci_hold_request_n};
    req_s1_next = pci_req_n;
    req_s2_next = req_s1_reg;
    req_s3_next = req_s2_reg;
    strobe_next = (strobe_sync_reg[1] == strobe_sync_reg[2]) ? strobe_sync_reg[2] : strobe_reg;
    hold_next = (hold_sync_reg[1] == hold_sync_reg[2]) ? hold_sync_reg[2] : hold_reg;
    req_next = (req_s2_reg == req_s3_reg) ? req_s3_reg : req_reg;
  end
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      strobe_sync_reg <= 3'h7;
      hold_sync_reg <= 3'h7;
      req_s1_reg <= 4'hf;
      req_s2_reg <= 4'hf;
      req_s3_reg <= 4'hf;
      strobe_reg <= 1'b1;
      hold_reg <= 1'b1;
      req_reg <= 4'hf;
    end else begin
      strobe_sync_reg <= strobe_sync_next;
      hold_sync_reg <= hold_sync_next;
      req_s1_reg <= req_s1_next;
      req_s2_reg <= req_s2_next;
      req_s3_reg <= req_s3_next;
      strobe_reg <= strobe_next;
      hold_reg <= hold_next;
      req_reg <= req_next;
    end
  end
  // =====================================================
  // mode capture
  ntt_mode_t mode_reg, mode_next;
  logic strobe_prev_reg, strobe_prev_next;
  logic strobe_fall;
  assign strobe_fall = strobe_prev_reg & ~strobe_reg;
  always_comb begin
    strobe_prev_next = strobe_reg;
    mode_next = mode_reg;
    if (strobe_reg) begin
      mode_next = NTT_NORMAL;
    end else if (strobe_fall) begin
      unique case (req_reg)
        `NTT_CODE_NAND: mode_next = NTT_NAND;
        `NTT_CODE_ID: mode_next = NTT_ID;
        `NTT_CODE_OFF: mode_next = NTT_NORMAL;
        default: mode_next = mode_reg;
      endcase
    end
  end
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      mode_reg <= NTT_NORMAL;
      strobe_prev_reg <= 1'b1;
    end else begin
      mode_reg <= mode_next;
      strobe_prev_reg <= strobe_prev_next;
    end
  end
  assign mode = mode_reg;
  // =====================================================
  // chains, all 72 pins enter each vector, pins past the chain length are bypassed
  logic [3:0] chain_out;
  ntt_chain_if ch_if[4] ();
  assign ch_if[0].members = chain0_pins;
  assign ch_if[1].members = chain1_pins;
  assign ch_if[2].members = chain2_pins;
  assign ch_if[3].members = chain3_pins;
  assign ch_if[0].len = 7'(`NTT_CH0_LEN);
  assign ch_if[1].len = 7'(`NTT_CH1_LEN);
  assign ch_if[2].len = 7'(`NTT_CH2_LEN);
  assign ch_if[3].len = 7'(`NTT_CH3_LEN);
  genvar c;
  generate
    for (c = 0; c < 4; c++) begin : g_chain
      ntt_nand_chain u_chain (
        .ch(ch_if[c])
      );
      assign chain_out[c] = ch_if[c].out;
    end
  endgenerate
  // =====================================================
  // output steering, registered
  logic [3:0] gnt_reg, gnt_next;
  logic [31:0] ad_reg, ad_next;
  logic ad_oe_reg, ad_oe_next;
  logic float_reg, float_next;
  always_comb begin
    gnt_next = func_gnt_n;
    ad_next = func_ad_o;
    ad_oe_next = func_ad_oe;
    float_next = 1'b0;
    unique case (mode_next)
      NTT_NAND: begin
        gnt_next = chain_out;
        ad_oe_next = 1'b0;
        float_next = 1'b1;
      end
      NTT_ID: begin
        ad_oe_next = 1'b1;
        if (hold_reg) begin
          ad_next = {`NTT_DEV_ID, 8'h00, `NTT_REV_ID};
        end else begin
          ad_next = `NTT_MFG_ID;
        end
      end
      NTT_NORMAL: begin
      end
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      gnt_reg <= 4'hf;
      ad_reg <= 32'h0000_0000;
      ad_oe_reg <= 1'b0;
      float_reg <= 1'b0;
    end else begin
      gnt_reg <= gnt_next;
      ad_reg <= ad_next;
      ad_oe_reg <= ad_oe_next;
      float_reg <= float_next;
    end
  end
  assign pci_gnt_n = gnt_reg;
  assign ad_o = ad_reg;
  assign ad_oe = ad_oe_reg;
  assign outputs_float = float_reg;
  assign pulls_enable = 1'b1;
  // =====================================================
  // checks
  sequence strobe_enter_s;
    $fell(strobe_reg) && req_reg == `NTT_CODE_NAND;
  endsequence
  sequence nand_active_s;
    mode_reg == NTT_NAND && outputs_float && !ad_oe;
  endsequence
  nand_entry_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    strobe_enter_s |=> nand_active_s)
    else $error("nand mode not entered");
  strobe_release_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    strobe_reg |=> mode_reg == NTT_NORMAL)
    else $error("mode kept after strobe release");
  normal_pass_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    mode_next == NTT_NORMAL |=> pci_gnt_n == $past(func_gnt_n) && !outputs_float)
    else $error("normal outputs not passed");
  mode_hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !strobe_reg && !$fell(strobe_reg) |=> $stable(mode_reg))
    else $error("mode changed while strobe held");
  id_drive_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    mode_next == NTT_ID && hold_reg |=> ad_oe && ad_o == {`NTT_DEV_ID, 8'h00, `NTT_REV_ID})
    else $error("id code not driven");
  mfg_drive_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    mode_next == NTT_ID && !hold_reg |=> ad_oe && ad_o == `NTT_MFG_ID)
    else $error("manufacturer code not driven");
  disable_code_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    $fell(strobe_reg) && req_reg == `NTT_CODE_OFF |=> mode_reg == NTT_NORMAL)
    else $error("disable code ignored");
  chain_route_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    mode_next == NTT_NAND |=> pci_gnt_n == $past(chain_out) && !ad_oe)
    else $error("chain not on grants");
  nand_stay_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    mode_reg == NTT_NAND && !strobe_reg && !$fell(strobe_reg) |=> mode_reg == NTT_NAND)
    else $error("nand mode dropped");
  pulls_on_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    outputs_float |-> pulls_enable)
    else $error("pulls disabled in chain mode");
endmodule // ntt_test_ctrl

// ==== sim/ntt_ate.sv ====
`timescale 1ns/10ps
// ==========================================
// board tester driving strap and chain pins
module ntt_ate (
  // clock
  input wire logic clk_sys,
  // strap pins
  output logic test_strobe_n,
  output logic [3:0] pci_req_n,
  output logic pci_hold_request_n,
  // chain members, all four chains
  output logic [3:0][71:0] chain_pins
);
  initial begin
    test_strobe_n = 1'b1;
    pci_req_n = 4'hf;
    pci_hold_request_n = 1'b1;
    chain_pins = '1;
  end
  // code settles before strobe falls
  task automatic strap(input logic [3:0] code, input logic hold);
    @(posedge clk_sys) #2;
    pci_req_n = code;
    pci_hold_request_n = hold;
    repeat (4) @(posedge clk_sys);
    #2 test_strobe_n = 1'b0;
  endtask
  task automatic unstrap();
    @(posedge clk_sys) #2;
    test_strobe_n = 1'b1;
    pci_req_n = 4'hf;
    repeat (6) @(posedge clk_sys);
    #2;
  endtask
  task automatic set_hold(input logic v);
    @(posedge clk_sys) #2;
    pci_hold_request_n = v;
  endtask
  task automatic poke(input int ch, input int idx, input logic v);
    @(posedge clk_sys) #2;
    chain_pins[ch][idx] = v;
  endtask
endmodule // ntt_ate

// ==== sim/ntt_test_ctrl_tb.sv ====
`timescale 1ns/10ps
`include "ntt_defines.svh"
module ntt_test_ctrl_tb;
  import ntt_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic test_strobe_n, pci_hold_request_n, ad_oe, outputs_float, pulls_enable;
  logic [3:0] pci_req_n, pci_gnt_n;
  logic [3:0][71:0] chain_pins;
  logic [3:0] func_gnt_n = 4'h5;
  logic [31:0] func_ad_o = 32'hcafe_0001;
  logic func_ad_oe = 1'b1;
  logic [31:0] ad_o;
  ntt_mode_t mode;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  always #10 clk_sys = ~clk_sys;
  ntt_ate ate (.clk_sys, .test_strobe_n, .pci_req_n, .pci_hold_request_n, .chain_pins);
  ntt_test_ctrl DUT (.clk_sys, .resetn, .test_strobe_n, .pci_req_n, .pci_hold_request_n,
    .chain0_pins(chain_pins[0]), .chain1_pins(chain_pins[1]), .chain2_pins(chain_pins[2]),
    .chain3_pins(chain_pins[3]), .func_gnt_n, .func_ad_o, .func_ad_oe, .pci_gnt_n, .ad_o,
    .ad_oe, .outputs_float, .pulls_enable, .mode);
  // ==========================================
  // helpers
  task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic chain_exp(input logic [71:0] m, input int len);
    logic s;
    s = ~m[0];
    for (int k = 1; k < len; k++) s = ~(s & m[k]);
    return s;
  endfunction
  task automatic wait_mode(input ntt_mode_t m);
    for (int i = 0; i < 12 && mode !== m; i++) begin
      @(posedge clk_sys);
      #2;
    end
    @(posedge clk_sys) #2;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic test_nand();
    int chs[6] = '{0, 0, 1, 2, 3, 3};
    int idx[6] = '{0, 71, 70, 68, 66, 68};
    ate.strap(4'h2, 1'b0);
    wait_mode(NTT_NAND);
    check("mode", mode, NTT_NAND);
    check("float", outputs_float, 1'b1);
    check("ad_oe", ad_oe, 1'b0);
    check("pulls", pulls_enable, 1'b1);
    check("gnt idle", pci_gnt_n, 4'hf);
    for (int i = 0; i < 6; i++) begin
      ate.poke(chs[i], idx[i], 1'b0);
      repeat (3) @(posedge clk_sys);
      #2;
      check("gnt", pci_gnt_n, {chain_exp(chain_pins[3], 68), chain_exp(chain_pins[2], 70),
        chain_exp(chain_pins[1], 72), chain_exp(chain_pins[0], 72)});
      ate.poke(chs[i], idx[i], 1'b1);
    end
    ate.unstrap();
    check("mode", mode, NTT_NORMAL);
    check("gnt", pci_gnt_n, func_gnt_n);
    check("float", outputs_float, 1'b0);
    $display("test nand done");
  endtask
  task automatic test_id();
    ate.strap(4'he, 1'b1);
    wait_mode(NTT_ID);
    check("ad_oe", ad_oe, 1'b1);
    check("ad", ad_o, {`NTT_DEV_ID, 8'h00, `NTT_REV_ID});
    ate.set_hold(1'b0);
    repeat (6) @(posedge clk_sys);
    #2;
    check("ad", ad_o, `NTT_MFG_ID);
    ate.unstrap();
    check("ad", ad_o, func_ad_o);
    $display("test id done");
  endtask
  task automatic test_off();
    logic [3:0] codes[2] = '{4'hf, 4'hf};
    for (int i = 0; i < 2; i++) begin
      ate.strap(codes[i], i[0]);
      repeat (8) @(posedge clk_sys);
      #2;
      check("mode", mode, NTT_NORMAL);
      check("float", outputs_float, 1'b0);
      ate.unstrap();
      resetn = 1'b0;
      @(posedge clk_sys) #2;
      resetn = 1'b1;
    end
    $display("test off done");
  endtask
  task automatic test_reset_nand();
    ate.strap(4'h2, 1'b1);
    wait_mode(NTT_NAND);
    resetn = 1'b0;
    @(posedge clk_sys) #2;
    check("mode", mode, NTT_NORMAL);
    check("float", outputs_float, 1'b0);
    resetn = 1'b1;
    ate.unstrap();
    $display("test reset done");
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    #2;
    check("gnt", pci_gnt_n, 4'hf);
    check("ad_oe", ad_oe, 1'b0);
    resetn = 1'b1;
    test_nand();
    test_id();
    test_off();
    test_reset_nand();
    report_and_stop();
  end
endmodule // ntt_test_ctrl_tb
